/* ssed_stage2_decode.sv */
// Stage-2 stream entry decode, legality check and output-address check behind APB
//
// What this block does
// - Inner and outer walk cacheability decode identically into four attribute codes.
// - Walk shareability decodes normally; reserved code 01 acts as non-shareable.
// - Both walk cacheabilities non-cacheable forces outer shareable walks.
// - Granule codes 4KB, 64KB, 16KB, reserved; ignored with stage 2 off.
// - 32-bit table format forces an effective 4KB granule.
// - 64-bit format with reserved or unsupported granule makes the entry illegal.
// - Physical size codes map to 32 through 52 bits for fault checks.
// - Code 111 acts as 110; earliest revision treats both as 101.
// - 32-bit format ignores the size field and uses 40 bits.
// - 64-bit format caps the effective size at the implemented output size.
// - Output address bits between 51 and the effective size raise a size fault.
// - Granules below 64KB force output bits 51:48 to zero.
// - Unsupported format, or secure entry with 32-bit format, is illegal.
// - Endianness bit selects little or big; unimplemented endianness is illegal.
// - Clear access flag faults or is taken as set, unless hardware update on.
// - Protected walk to a device page with both stages on gives permission fault.
// - Without protection, device walk accesses become normal non-cacheable when capable.
// - Hardware update pair decodes to off, access, access plus dirty.
// - Hardware update bits illegal with 32-bit format or missing capability.
// - Fault record and stall bits act only when stage 2 is enabled.
// - When capable, secure streams with stage 2 on take walk NS from the entry bit; output NS ORs both entry NS bits with controls SA and SW.
// - Table base gives address bits 51:4; 64KB with 52 bits clears 5:0.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "ssed_defines.svh"

module ssed_stage2_decode (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Decode results
	output logic             ENTRY_ILLEGAL,
	output logic             CHECK_DONE
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Size code to address width in bits
	function automatic logic [5:0] ps_width(input logic [2:0] code);
		logic [5:0] w;
		w = `SSED_W_48;
		case (code)
			3'h0: w = 6'h20;
			3'h1: w = 6'h24;
			3'h2: w = 6'h28;
			3'h3: w = 6'h2A;
			3'h4: w = 6'h2C;
			3'h5: w = 6'h30;
			default: w = 6'h34;
		endcase
		return w;
	endfunction

	// Reserved size codes folded per revision
	function automatic logic [2:0] ps_fold(input logic [2:0] code, input logic rev0);
		logic [2:0] c;
		c = code;
		if (rev0 && code >= `SSED_PS_52) begin
			c = `SSED_PS_48;
		end else if (code == `SSED_PS_RSVD) begin
			c = `SSED_PS_52;
		end
		return c;
	endfunction

	// Any address bit from the given width up to bit 51 set
	function automatic logic size_fault(input logic [51:0] addr, input logic [5:0] width);
		logic f;
		f = 1'b0;
		for (int i = 0; i < 52; i++) begin
			if (6'(i) >= width && addr[i]) begin
				f = 1'b1;
			end
		end
		return f;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	ssed_pkg::ssed_state_t st;
	ssed_pkg::ssed_state_t next_st;

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	logic        s2_on;
	logic        s1_on;
	logic        fmt64;
	logic        secure;
	logic [1:0]  inner;
	logic [1:0]  outer;
	logic [1:0]  eff_share;
	logic [1:0]  eff_gran;
	logic        gran_ok;
	logic        bad_gran;
	logic        bad_fmt;
	logic        bad_endian;
	logic        bad_hw;
	logic        illegal;
	logic [2:0]  ps_prog;
	logic [2:0]  ps_cap;
	logic [5:0]  eff_width;
	logic [1:0]  hw_mode;
	logic        hw_af_on;
	logic        affd_eff;
	logic        ptw_eff;
	logic        rec_eff;
	logic        stall_eff;
	logic        walk_ns;
	logic        out_ns;
	logic        sa_eff;
	logic [51:0] ttb;
	logic [51:0] oaddr;
	logic        as_fault;
	logic        perm_fault;
	logic        af_fault;
	logic        walk_nc;
	logic [31:0] status;

	// Enables and format selection
	assign s2_on  = st.ctrl[`SSED_CTRL_S2EN] & st.caps[`SSED_CAP_S2P];
	assign s1_on  = st.ctrl[`SSED_CTRL_S1EN];
	assign fmt64  = st.w5[`SSED_W5_FMT];
	assign secure = st.ctrl[`SSED_CTRL_SECURE];

	// Walk attributes, identical decode for both levels
	assign inner = st.w5[`SSED_W5_INNER];
	assign outer = st.w5[`SSED_W5_OUTER];

	// Walk shareability with non-cacheable override
	always_comb begin
		if (inner == `SSED_C2_00 && outer == `SSED_C2_00) begin
			eff_share = `SSED_C2_10;
		end else if (st.w5[`SSED_W5_SHARE] == `SSED_C2_01) begin
			eff_share = `SSED_C2_00;
		end else begin
			eff_share = st.w5[`SSED_W5_SHARE];
		end
	end

	// Granule decode and support check
	always_comb begin
		case (st.w5[`SSED_W5_GRAN])
			`SSED_C2_00: gran_ok = st.caps[`SSED_CAP_G4K];
			`SSED_C2_01: gran_ok = st.caps[`SSED_CAP_G64K];
			`SSED_C2_10: gran_ok = st.caps[`SSED_CAP_G16K];
			default:     gran_ok = 1'b0;
		endcase
		if (!s2_on || !fmt64) begin
			eff_gran = `SSED_C2_00;
		end else begin
			eff_gran = st.w5[`SSED_W5_GRAN];
		end
	end
	assign bad_gran = s2_on & fmt64 & ~gran_ok;

	// Effective output size
	assign ps_prog = ps_fold(st.w5[`SSED_W5_PS], st.ctrl[`SSED_CTRL_REV0]);
	assign ps_cap  = ps_fold(st.caps[`SSED_CAP_OAS], st.ctrl[`SSED_CTRL_REV0]);
	always_comb begin
		if (!fmt64) begin
			eff_width = `SSED_W_40;
		end else if (ps_prog > ps_cap) begin
			eff_width = ps_width(ps_cap);
		end else begin
			eff_width = ps_width(ps_prog);
		end
	end

	// Format and endianness legality
	assign bad_fmt = s2_on & ((~fmt64 & ~st.caps[`SSED_CAP_TTF32]) | (fmt64 & ~st.caps[`SSED_CAP_TTF64])
		| (secure & ~fmt64));
	assign bad_endian = s2_on & ((st.w5[`SSED_W5_ENDI] & st.caps[`SSED_CAP_ENDIAN] == `SSED_C2_10)
		| (~st.w5[`SSED_W5_ENDI] & st.caps[`SSED_CAP_ENDIAN] == `SSED_C2_11));

	// Hardware flag update legality and mode
	assign bad_hw = s2_on & (((st.w5[`SSED_W5_HA] | st.w5[`SSED_W5_HD]) & ~fmt64)
		| (st.w5[`SSED_W5_HA] & st.caps[`SSED_CAP_HARDWARE_FLAG_UPDATE] == `SSED_C2_00)
		| (st.w5[`SSED_W5_HD] & st.caps[`SSED_CAP_HARDWARE_FLAG_UPDATE] <= `SSED_C2_01));
	always_comb begin
		hw_mode = `SSED_C2_00;
		if (s2_on && fmt64) begin
			case ({st.w5[`SSED_W5_HD], st.w5[`SSED_W5_HA]})
				`SSED_C2_10: hw_mode = `SSED_C2_01;
				`SSED_C2_11: hw_mode = `SSED_C2_10;
				default:     hw_mode = `SSED_C2_00;
			endcase
		end
	end
	assign hw_af_on = hw_mode != `SSED_C2_00;
	assign affd_eff = st.w5[`SSED_W5_AFFD] & ~hw_af_on;

	// Overall legality
	assign illegal = bad_gran | bad_fmt | bad_endian | bad_hw;

	// Walk protection and fault reporting controls
	assign ptw_eff   = st.w5[`SSED_W5_PTW] & s1_on & s2_on;
	assign rec_eff   = st.w5[`SSED_W5_RECORD] & s2_on;
	assign stall_eff = st.w5[`SSED_W5_STALL] & s2_on;

	// Secure stream NS values
	assign sa_eff = st.ctrl[`SSED_CTRL_SA] | st.ctrl[`SSED_CTRL_SW];
	always_comb begin
		if (secure && st.caps[`SSED_CAP_SECURE_SECOND_STAGE_CAP] && s2_on) begin
			walk_ns = st.w6[`SSED_W6_NSW];
			out_ns  = st.w6[`SSED_W6_NSW] | sa_eff | st.w6[`SSED_W6_NSA];
		end else begin
			walk_ns = 1'b1;
			out_ns  = 1'b1;
		end
	end

	// Table base with alignment
	always_comb begin
		ttb = {st.w7[`SSED_W7_TTB], st.w6[`SSED_W6_TTB], 4'h0};
		if (eff_gran == `SSED_C2_01 && eff_width == ps_width(`SSED_PS_52)) begin
			ttb[5:0] = 6'h00;
		end
	end

	// Output address check
	always_comb begin
		oaddr = {st.oaddr_hi[`SSED_OADDR_HI_ADDR], st.oaddr_lo};
		if (eff_gran != `SSED_C2_01) begin
			oaddr[51:48] = 4'h0;
		end
	end
	assign as_fault   = s2_on & size_fault(oaddr, eff_width);
	assign perm_fault = ptw_eff & st.oaddr_hi[`SSED_OADDR_HI_WALK] & st.oaddr_hi[`SSED_OADDR_HI_DEV];
	assign walk_nc    = ~st.w5[`SSED_W5_PTW] & st.caps[`SSED_CAP_NNC]
		& st.oaddr_hi[`SSED_OADDR_HI_WALK] & st.oaddr_hi[`SSED_OADDR_HI_DEV];
	assign af_fault   = s2_on & ~st.oaddr_hi[`SSED_OADDR_HI_AF] & ~affd_eff & ~hw_af_on;

	// Status word
	assign status = {3'h0, st.phase, walk_nc, ptw_eff, out_ns, walk_ns, stall_eff, rec_eff, affd_eff,
		hw_mode, outer, inner, eff_share, eff_gran, ps_width(ps_prog) == eff_width, eff_width[5:1],
		bad_hw, bad_endian, bad_fmt, bad_gran, illegal};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.illegal = illegal;
		// Setup phase: capture read data and error
		if (PSEL && !PENABLE) begin
			next_st.slverr = 1'b0;
			next_st.rdata = `SSED_ZERO32;
			case (PADDR)
				`SSED_OFF_ENTRY_W5: next_st.rdata = st.w5;
				`SSED_OFF_ENTRY_W6: next_st.rdata = st.w6;
				`SSED_OFF_ENTRY_W7: next_st.rdata = st.w7;
				`SSED_OFF_CTRL:     next_st.rdata = {26'h000_0000, st.ctrl};
				`SSED_OFF_CAPS:     next_st.rdata = {17'h0_0000, st.caps};
				`SSED_OFF_STATUS:   next_st.rdata = status;
				`SSED_OFF_OADDR_LO: next_st.rdata = st.oaddr_lo;
				`SSED_OFF_OADDR_HI: next_st.rdata = st.oaddr_hi;
				`SSED_OFF_RESULT:   next_st.rdata = {24'h00_0000, st.result};
				`SSED_OFF_TTB_LO:   next_st.rdata = ttb[31:0];
				`SSED_OFF_TTB_HI:   next_st.rdata = {12'h000, ttb[51:32]};
				default:            next_st.slverr = 1'b1;
			endcase
		end
		// Access phase: writes take effect
		if (PSEL && PENABLE && PWRITE) begin
			case (PADDR)
				`SSED_OFF_ENTRY_W5: next_st.w5 = PWDATA;
				`SSED_OFF_ENTRY_W6: next_st.w6 = PWDATA;
				`SSED_OFF_ENTRY_W7: next_st.w7 = PWDATA;
				`SSED_OFF_CTRL:     next_st.ctrl = PWDATA[5:0];
				`SSED_OFF_CAPS:     next_st.caps = PWDATA[14:0];
				`SSED_OFF_OADDR_LO: next_st.oaddr_lo = PWDATA;
				`SSED_OFF_OADDR_HI: begin
					next_st.oaddr_hi = PWDATA;
					next_st.phase = ssed_pkg::SSED_PH_EVAL;
				end
				default: next_st.phase = st.phase;
			endcase
		end
		// Evaluate one output-address check
		case (st.phase)
			ssed_pkg::SSED_PH_EVAL: begin
				next_st.phase = ssed_pkg::SSED_PH_IDLE;
				next_st.done = 1'b1;
				if (illegal) begin
					next_st.result = 8'h01;
				end else begin
					next_st.result = {1'b0, walk_nc, stall_eff & (as_fault | perm_fault | af_fault),
						rec_eff & (as_fault | perm_fault | af_fault), af_fault, perm_fault, as_fault,
						1'b0};
				end
			end
			default: begin
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st <= '{w5: `SSED_ZERO32, w6: `SSED_ZERO32, w7: `SSED_ZERO32, ctrl: `SSED_CTRL_RESET,
				caps: `SSED_CAPS_RESET, oaddr_lo: `SSED_ZERO32, oaddr_hi: `SSED_ZERO32,
				phase: ssed_pkg::SSED_PH_IDLE, rdata: `SSED_ZERO32, slverr: 1'b0, result: 8'h00,
				done: 1'b0, illegal: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign PREADY        = 1'b1;
	assign PRDATA        = st.rdata;
	assign PSLVERR       = st.slverr & PSEL & PENABLE;
	assign ENTRY_ILLEGAL = st.illegal;
	assign CHECK_DONE    = st.done;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	sequence hi_write_s;
		PSEL && PENABLE && PWRITE && PADDR == `SSED_OFF_OADDR_HI;
	endsequence
	sequence eval_s;
		st.phase == ssed_pkg::SSED_PH_EVAL;
	endsequence

	a_share_nc_osh: assert property (inner == 2'h0 && outer == 2'h0 |-> eff_share == 2'h2)
		else $error("Non-cacheable walk not outer shareable");
	a_share_rsvd: assert property (st.w5[13:12] == 2'h1 && (inner != 2'h0 || outer != 2'h0)
		|-> eff_share == 2'h0)
		else $error("Reserved shareability not non-shareable");
	a_gran_fmt32: assert property (!fmt64 |-> eff_gran == 2'h0)
		else $error("32-bit format granule not 4KB");
	a_width_fmt32: assert property (!fmt64 |-> eff_width == 6'd40)
		else $error("32-bit format width not 40");
	a_width_capped: assert property (fmt64 |-> eff_width <= ps_width(ps_cap))
		else $error("Effective size exceeds cap");
	a_eval_abort: assert property (hi_write_s ##1 eval_s |=> CHECK_DONE && (st.result[0] == $past(illegal)))
		else $error("Check result does not reflect legality");
	a_secure_fmt: assert property (s2_on && secure && !fmt64 |=> ENTRY_ILLEGAL)
		else $error("Secure 32-bit entry not flagged");
	a_ptw_gate: assert property (perm_fault |-> s1_on && s2_on && st.w5[22])
		else $error("Permission fault without both stages");
	a_flags_off: assert property (!s2_on |-> !rec_eff && !stall_eff)
		else $error("Record or stall with stage 2 off");
	a_ttb_align: assert property (eff_gran == 2'h1 && eff_width == 6'd52 |-> ttb[5:0] == 6'h00)
		else $error("Table base not 64-byte aligned");

endmodule

/* ssed_defines.svh */
// Register offsets, field positions and constant codes for the stage-2 entry decoder
`ifndef SSED_DEFINES_SVH
`define SSED_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSED_OFF_ENTRY_W5   8'h00
`define SSED_OFF_ENTRY_W6   8'h04
`define SSED_OFF_ENTRY_W7   8'h08
`define SSED_OFF_CTRL       8'h0C
`define SSED_OFF_CAPS       8'h10
`define SSED_OFF_STATUS     8'h14
`define SSED_OFF_OADDR_LO   8'h18
`define SSED_OFF_OADDR_HI   8'h1C
`define SSED_OFF_RESULT     8'h20
`define SSED_OFF_TTB_LO     8'h24
`define SSED_OFF_TTB_HI     8'h28

// ----------------------------------------
// Entry word 5 (entry bits 191:160) fields
// ----------------------------------------
`define SSED_W5_INNER       9:8
`define SSED_W5_OUTER       11:10
`define SSED_W5_SHARE       13:12
`define SSED_W5_GRAN        15:14
`define SSED_W5_PS          18:16
`define SSED_W5_FMT         19
`define SSED_W5_ENDI        20
`define SSED_W5_AFFD        21
`define SSED_W5_PTW         22
`define SSED_W5_HD          23
`define SSED_W5_HA          24
`define SSED_W5_STALL       25
`define SSED_W5_RECORD      26
// Entry word 6 and 7 fields
`define SSED_W6_NSW         0
`define SSED_W6_NSA         1
`define SSED_W6_TTB         31:4
`define SSED_W7_TTB         19:0

// ----------------------------------------
// Control, capability and output-address high word bits
// ----------------------------------------
`define SSED_CTRL_S1EN      0
`define SSED_CTRL_S2EN      1
`define SSED_CTRL_SECURE    2
`define SSED_CTRL_REV0      3
`define SSED_CTRL_SW        4
`define SSED_CTRL_SA        5
`define SSED_CAP_OAS        2:0
`define SSED_CAP_HARDWARE_FLAG_UPDATE       4:3
`define SSED_CAP_ENDIAN     6:5
`define SSED_CAP_TTF32      7
`define SSED_CAP_TTF64      8
`define SSED_CAP_G4K        9
`define SSED_CAP_G16K       10
`define SSED_CAP_G64K       11
`define SSED_CAP_NNC        12
`define SSED_CAP_SECURE_SECOND_STAGE_CAP       13
`define SSED_CAP_S2P        14
`define SSED_OADDR_HI_ADDR  19:0
`define SSED_OADDR_HI_AF    29
`define SSED_OADDR_HI_DEV   30
`define SSED_OADDR_HI_WALK  31

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define SSED_C2_00          2'h0
`define SSED_C2_01          2'h1
`define SSED_C2_10          2'h2
`define SSED_C2_11          2'h3
`define SSED_PS_40          3'h2
`define SSED_PS_48          3'h5
`define SSED_PS_52          3'h6
`define SSED_PS_RSVD        3'h7
`define SSED_W_40           6'h28
`define SSED_W_48           6'h30
`define SSED_ZERO32         32'h0000_0000
`define SSED_CAPS_RESET     15'h7FFF
`define SSED_CTRL_RESET     6'h00

`endif

/* ssed_pkg.sv */
// Types shared by the stage-2 entry decoder
package ssed_pkg;

	// Evaluation phase of an output-address check
	typedef enum logic [0:0] {
		SSED_PH_IDLE = 1'b0,
		SSED_PH_EVAL = 1'b1
	} ssed_phase_t;

	// Whole state of the decoder
	typedef struct packed {
		logic [31:0] w5;
		logic [31:0] w6;
		logic [31:0] w7;
		logic [5:0]  ctrl;
		logic [14:0] caps;
		logic [31:0] oaddr_lo;
		logic [31:0] oaddr_hi;
		ssed_phase_t phase;
		logic [31:0] rdata;
		logic        slverr;
		logic [7:0]  result;
		logic        done;
		logic        illegal;
	} ssed_state_t;

endpackage

/* ssed_entry_mem.sv */
// Memory model holding stream entry images for the decoder bench
`timescale 1ns/1ps

module ssed_entry_mem (
	// Image select
	input  wire logic [2:0]  idx,
	// Entry words of the selected image
	output logic      [31:0] w5,
	output logic      [31:0] w6,
	output logic      [31:0] w7
);
	// Table base and walk bits are shared by every image
	assign w6 = 32'hFFFF_FFF0;
	assign w7 = 32'h000F_FFFF;

	// Stage-2 word of each image
	always_comb begin
		case (idx)
			3'h0:    w5 = 32'h000D_4000;  // 64KB granule, 48-bit size
			3'h1:    w5 = 32'h000D_0000;  // 4KB granule, 48-bit size
			3'h2:    w5 = 32'h000A_0000;  // 4KB granule, 40-bit size
			3'h3:    w5 = 32'h002A_0000;  // As 2, access fault disabled
			3'h4:    w5 = 32'h000E_4000;  // 64KB granule, 52-bit size
			3'h5:    w5 = 32'h004A_0000;  // As 2, protected walk
			3'h7:    w5 = 32'h060A_0000;  // As 2, fault record and stall
			default: w5 = 32'h0008_C000;  // Reserved granule
		endcase
	end
endmodule

/* tb.sv */
// Self-checking bench for the stage-2 entry decoder
`timescale 1ns/1ps
`include "ssed_defines.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, gt); end end

module tb;
	// ----------------------------------------
	// Case tables, signals and instances
	// ----------------------------------------
	// Entry word, walk bits, control and caps beside masked status
	typedef struct {
		logic [31:0] w5;
		logic [1:0]  ns;
		logic [5:0]  ctrl;
		logic [14:0] caps;
		logic [31:0] mask;
		logic [31:0] exp;
	} ssed_row_t;
	// Image, high address word and expected result bits
	typedef struct {
		logic [2:0] idx;
		logic [31:0] hi;
		logic [6:0] res;
	} ssed_chk_t;

	localparam logic [14:0] CB = 15'h7F9E;  // Full caps, 52-bit output size

	logic        core_clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        entry_illegal;
	logic        check_done;
	logic [2:0]  mem_idx;
	logic [31:0] mem_w5;
	logic [31:0] mem_w6;
	logic [31:0] mem_w7;
	logic [31:0] rd;
	logic        er;
	int          miscompares;
	int          compares;
	int          cycles;
	int          n;
	ssed_row_t   rows [$];
	ssed_chk_t   chks [$];
	logic [4:0]  half [8];

	ssed_stage2_decode i_ssed_stage2_decode (
		.CORE_CLK      (core_clk),
		.RST           (rst),
		.PSEL          (psel),
		.PENABLE       (penable),
		.PWRITE        (pwrite),
		.PADDR         (paddr),
		.PWDATA        (pwdata),
		.PRDATA        (prdata),
		.PREADY        (pready),
		.PSLVERR       (pslverr),
		.ENTRY_ILLEGAL (entry_illegal),
		.CHECK_DONE    (check_done)
	);

	ssed_entry_mem i_ssed_entry_mem (
		.idx (mem_idx),
		.w5  (mem_w5),
		.w6  (mem_w6),
		.w7  (mem_w7)
	);

	// ----------------------------------------
	// Clock, timeout and bus tasks
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Cuts a hang short
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			results();
		end
	end

	task automatic results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic load(input logic [31:0] w5, input logic [31:0] w6, input logic [5:0] c, input logic [14:0] k);
		apb(1'b1, `SSED_OFF_ENTRY_W5, w5);
		apb(1'b1, `SSED_OFF_ENTRY_W6, w6);
		apb(1'b1, `SSED_OFF_CTRL, {26'h000_0000, c});
		apb(1'b1, `SSED_OFF_CAPS, {17'h0_0000, k});
	endtask

	task automatic status;
		apb(1'b0, `SSED_OFF_STATUS, 32'h0000_0000);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rows = '{
			'{32'h0008_3900, 2'h0, 6'h02, CB, 32'h0007_E001, 32'h0004_E000},
			'{32'h0008_3000, 2'h0, 6'h02, CB, 32'h0000_6001, 32'h0000_4000},
			'{32'h0008_1500, 2'h0, 6'h02, CB, 32'h0000_6001, 32'h0000_0000},
			'{32'h0008_4000, 2'h0, 6'h02, CB, 32'h0000_1801, 32'h0000_0800},
			'{32'h0008_8000, 2'h0, 6'h02, CB, 32'h0000_1801, 32'h0000_1000},
			'{32'h0006_C000, 2'h0, 6'h02, CB, 32'h0000_1BE1, 32'h0000_0280},
			'{32'h0008_C000, 2'h0, 6'h02, CB, 32'h0000_001F, 32'h0000_0003},
			'{32'h0008_8000, 2'h0, 6'h02, 15'h7B9E, 32'h0000_001F, 32'h0000_0003},
			'{32'h0008_C000, 2'h0, 6'h00, CB, 32'h0000_001F, 32'h0000_0000},
			'{32'h0000_0000, 2'h0, 6'h06, CB, 32'h0000_001F, 32'h0000_0005},
			'{32'h0008_0000, 2'h0, 6'h02, 15'h7E9E, 32'h0000_001F, 32'h0000_0005},
			'{32'h0018_0000, 2'h0, 6'h02, 15'h7FDE, 32'h0000_001F, 32'h0000_0009},
			'{32'h0108_0000, 2'h0, 6'h02, 15'h7F86, 32'h0000_001F, 32'h0000_0011},
			'{32'h0088_0000, 2'h0, 6'h02, 15'h7F8E, 32'h0000_001F, 32'h0000_0011},
			'{32'h0100_0000, 2'h0, 6'h02, CB, 32'h0000_001F, 32'h0000_0011},
			'{32'h0088_0000, 2'h0, 6'h02, CB, 32'h0018_001F, 32'h0008_0000},
			'{32'h0188_0000, 2'h0, 6'h02, CB, 32'h0018_001F, 32'h0010_0000},
			'{32'h0028_0000, 2'h0, 6'h02, CB, 32'h0020_0001, 32'h0020_0000},
			'{32'h01A8_0000, 2'h0, 6'h02, CB, 32'h0020_0001, 32'h0000_0000},
			'{32'h0608_0000, 2'h0, 6'h02, CB, 32'h00C0_0001, 32'h00C0_0000},
			'{32'h0608_0000, 2'h0, 6'h00, CB, 32'h00C0_0001, 32'h0000_0000},
			'{32'h0048_0000, 2'h0, 6'h03, CB, 32'h0400_0001, 32'h0400_0000},
			'{32'h0048_0000, 2'h0, 6'h02, CB, 32'h0400_0001, 32'h0000_0000},
			'{32'h0008_0000, 2'h0, 6'h02, CB, 32'h0800_0001, 32'h0800_0000},
			'{32'h0008_0000, 2'h1, 6'h06, CB, 32'h0300_0001, 32'h0300_0000},
			'{32'h0008_0000, 2'h0, 6'h26, CB, 32'h0300_0001, 32'h0200_0000}
		};
		chks = '{'{3'h0, 32'h2001_0000, 7'h02}, '{3'h0, 32'h2000_8000, 7'h00}, '{3'h1, 32'h2001_0000, 7'h00},
			'{3'h2, 32'h2000_0100, 7'h02}, '{3'h2, 32'h2000_0080, 7'h00}, '{3'h2, 32'h0000_0000, 7'h08},
			'{3'h3, 32'h0000_0000, 7'h00}, '{3'h5, 32'hE000_0000, 7'h04}, '{3'h6, 32'h2000_0000, 7'h01},
			'{3'h2, 32'hC000_0000, 7'h48}, '{3'h7, 32'h0000_0000, 7'h38}};
		half = '{5'h10, 5'h12, 5'h14, 5'h15, 5'h16, 5'h18, 5'h1A, 5'h1A};
		miscompares = 0;
		compares = 0;
		cycles = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		mem_idx = 3'h0;
		repeat (20) @(posedge core_clk);
		`CHK("reset ready", 1'b1, pready)
		`CHK("reset illegal", 1'b0, entry_illegal)
		`CHK("reset done", 1'b0, check_done)
		rst <= 1'b0;
		apb(1'b0, `SSED_OFF_CAPS, 32'h0000_0000);
		`CHK("caps reset", 32'h0000_7FFF, rd)
		apb(1'b0, `SSED_OFF_CTRL, 32'h0000_0000);
		`CHK("ctrl reset", 32'h0000_0000, rd)
		$display("test reset done");

		// Decode table; a walk access to a device page stands in the address word
		apb(1'b1, `SSED_OFF_OADDR_HI, 32'hC000_0000);
		foreach (rows[i]) begin
			load(rows[i].w5, {30'h0000_0000, rows[i].ns}, rows[i].ctrl, rows[i].caps);
			status();
			`CHK("status", rows[i].exp, rd & rows[i].mask)
			`CHK("illegal pin", rows[i].exp[0], entry_illegal)
		end
		$display("test decode table done");

		// Every size code, the cap and the earliest revision
		load(32'h0008_0000, 32'h0000_0000, 6'h02, CB);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, `SSED_OFF_ENTRY_W5, {12'h000, 1'b1, c[2:0], 16'h0000});
			status();
			`CHK("width", half[c], rd[9:5])
		end
		load(32'h000F_0000, 32'h0000_0000, 6'h0A, CB);
		status();
		`CHK("rev0 width", 5'h18, rd[9:5])
		load(32'h000E_0000, 32'h0000_0000, 6'h02, 15'h7F9B);
		status();
		`CHK("capped width", 5'h15, rd[9:5])
		$display("test size done");

		// Output-address checks
		foreach (chks[i]) begin
			mem_idx <= chks[i].idx;
			@(posedge core_clk);
			load(mem_w5, mem_w6, 6'h03, CB);
			apb(1'b1, `SSED_OFF_OADDR_LO, 32'h0000_0000);
			apb(1'b1, `SSED_OFF_OADDR_HI, chks[i].hi);
			n = 0;
			while (check_done !== 1'b1 && n < 8) begin
				@(negedge core_clk);
				n++;
			end
			`CHK("done pulse", 1'b1, check_done)
			apb(1'b0, `SSED_OFF_RESULT, 32'h0000_0000);
			`CHK("result", chks[i].res, rd[6:0])
		end
		$display("test address check done");

		// Table base alignment
		mem_idx <= 3'h4;
		@(posedge core_clk);
		load(mem_w5, mem_w6, 6'h02, CB);
		apb(1'b1, `SSED_OFF_ENTRY_W7, mem_w7);
		apb(1'b0, `SSED_OFF_TTB_LO, 32'h0000_0000);
		`CHK("base lo", 32'hFFFF_FFC0, rd)
		apb(1'b0, `SSED_OFF_TTB_HI, 32'h0000_0000);
		`CHK("base hi", 32'h000F_FFFF, rd)
		apb(1'b1, `SSED_OFF_ENTRY_W5, 32'h000E_0000);
		apb(1'b0, `SSED_OFF_TTB_LO, 32'h0000_0000);
		`CHK("base lo 4k", 32'hFFFF_FFF0, rd)
		$display("test table base done");

		// Unmapped and read-only places
		apb(1'b0, 8'h40, 32'h0000_0000);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0000_0000, rd)
		apb(1'b1, `SSED_OFF_STATUS, 32'hFFFF_FFFF);
		status();
		`CHK("status ro", 1'b0, rd[0])
		$display("test refused access done");
		results();
	end
endmodule
